//--- meter_seq_defs.svh
// constants for the measurement command sequencer
`ifndef METER_SEQ_DEFS_SVH
`define METER_SEQ_DEFS_SVH
`define MEM_DEPTH 1024
`define MEM_AW 10
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define DATA_W 32
`define COUNT_W 11
`define RANGE_W 4
`define RANGE_LOWEST 4'h0
`define RANGE_HIGHEST 4'h7
`define NPLC_MIN 3'h0
`define NPLC_MAX 3'h7
`define NPLC_DEF 3'h4
`define NPLC_W 3
`define TRIG_COUNT_DEF 11'h001
`define SAMPLE_COUNT_DEF 11'h001
`endif

//--- meter_seq_pkg.sv
// types for the measurement command sequencer
package meter_seq_pkg;
	typedef enum logic [3:0] {
		cmd_none = 4'h0, cmd_configure = 4'h1, cmd_measure = 4'h2, cmd_read = 4'h3,
		cmd_initiate = 4'h4, cmd_fetch = 4'h5, cmd_config_query = 4'h6,
		cmd_route = 4'h7, cmd_bus_trigger = 4'h8, cmd_set_counts = 4'h9
	} cmd_t;
	typedef enum logic [1:0] {arg_value = 2'h0, arg_min = 2'h1, arg_max = 2'h2, arg_def = 2'h3} arg_t;
	typedef enum logic [1:0] {src_immediate = 2'h0, src_bus = 2'h1, src_external = 2'h2} trig_src_t;
	typedef enum logic [2:0] {
		fn_volt = 3'h0, fn_ratio = 3'h1, fn_diff = 3'h2, fn_res = 3'h3, fn_fres = 3'h4, fn_temp = 3'h5
	} func_t;
	typedef enum logic [1:0] {
		junction_pair_probe = 2'h0, resistive_bead_probe = 2'h1, four_wire_rtd_probe = 2'h2,
		probe_default = 2'h3
	} probe_t;
	// gray along idle -> wait -> measure -> fetch
	typedef enum logic [1:0] {st_idle = 2'h0, st_wait = 2'h1, st_take = 2'h3, st_fetch = 2'h2} state_t;
	typedef enum logic [1:0] {mode_read = 2'h0, mode_init = 2'h1, mode_meas = 2'h2} mode_t;
endpackage

//--- meter_seq.sv
// measurement command sequencer with reading fifo and reading memory
`timescale 1ns/1ps
`default_nettype none
`include "meter_seq_defs.svh"

// ***************************************************
// output fifo
// ***************************************************
module reading_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic flush,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ff, rd_ff;
	logic [AW:0] cnt_ff;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem[rd_ff];
	// storage is not reset; only pointers and occupancy carry state
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ff] <= in_data;
		end
	end
	// pointers and occupancy
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else if (flush) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) wr_ff <= wr_ff + AW'(1);
			if (pop) rd_ff <= rd_ff + AW'(1);
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ***************************************************
// sequencer top
// ***************************************************
module meter_seq (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// command port
	input wire logic cmd_valid,
	input wire meter_seq_pkg::cmd_t cmd_code,
	output logic cmd_ready,
	input wire meter_seq_pkg::func_t cmd_func,
	input wire meter_seq_pkg::arg_t cmd_range_kind,
	input wire logic [`RANGE_W-1:0] cmd_range_value,
	input wire meter_seq_pkg::arg_t cmd_res_kind,
	input wire logic [`NPLC_W-1:0] cmd_res_nplc,
	input wire logic cmd_channel,
	input wire meter_seq_pkg::probe_t cmd_probe,
	input wire logic [3:0] cmd_probe_subtype,
	input wire meter_seq_pkg::trig_src_t cmd_trig_src,
	input wire logic [`COUNT_W-1:0] cmd_trig_count,
	input wire logic [`COUNT_W-1:0] cmd_sample_count,
	input wire logic cmd_no_store,
	// controller events
	input wire logic device_clear,
	input wire logic group_execute_trigger,
	input wire logic ext_trigger,
	// analog converter
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [`DATA_W-1:0] conv_data,
	// output buffer to controller
	output logic out_valid,
	input wire logic out_ready,
	output logic [`DATA_W-1:0] out_data,
	// status and settings
	output logic busy,
	output logic waiting_trigger,
	output logic memory_error,
	output logic [`COUNT_W-1:0] stored_count,
	output logic [`COUNT_W-1:0] stat_count,
	output logic active_channel,
	output logic [`RANGE_W-1:0] ch_range_0,
	output logic [`RANGE_W-1:0] ch_range_1,
	output logic ch_auto_0,
	output logic ch_auto_1,
	output logic [`NPLC_W-1:0] nplc,
	output logic [2:0] func_now,
	output logic [1:0] probe_now,
	output logic [3:0] probe_subtype_now
);
	meter_seq_pkg::state_t state_ff, nxt_state;
	meter_seq_pkg::mode_t mode_ff;
	meter_seq_pkg::trig_src_t src_ff;
	logic [`DATA_W-1:0] rmem [`MEM_DEPTH];
	logic [`COUNT_W-1:0] trig_cnt_ff, samp_cnt_ff, taken_ff, total_ff, fetch_ff;
	logic [`COUNT_W-1:0] wr_cnt_ff, stat_ff;
	logic [`DATA_W-1:0] fetch_data_ff;
	logic no_store_ff, pending_ff, err_ff, fetch_vld_ff, cq_ff;
	logic [`RANGE_W-1:0] rng_ff [2];
	logic auto_ff [2];
	logic [`NPLC_W-1:0] nplc_ff;
	logic chan_ff;
	meter_seq_pkg::func_t func_ff;
	meter_seq_pkg::probe_t probe_ff;
	logic [3:0] sub_ff;

	// range decode used for both channels
	function automatic logic [`RANGE_W:0] decode_range(meter_seq_pkg::arg_t k,
			logic [`RANGE_W-1:0] v);
		if (k == meter_seq_pkg::arg_min) return {1'b0, `RANGE_LOWEST};
		else if (k == meter_seq_pkg::arg_max) return {1'b0, `RANGE_HIGHEST};
		else if (k == meter_seq_pkg::arg_def) return {1'b1, `RANGE_HIGHEST};
		else return {1'b0, v};
	endfunction

	// resolution to integration setting
	function automatic logic [`NPLC_W-1:0] decode_res(meter_seq_pkg::arg_t k,
			logic [`NPLC_W-1:0] v);
		if (k == meter_seq_pkg::arg_min) return `NPLC_MAX; // finest = longest
		else if (k == meter_seq_pkg::arg_max) return `NPLC_MIN;
		else if (k == meter_seq_pkg::arg_def) return `NPLC_DEF;
		else return v;
	endfunction

	// command qualification
	wire idle = (state_ff == meter_seq_pkg::st_idle);
	wire init_lock = !idle && (mode_ff == meter_seq_pkg::mode_init);
	wire bus_trg_cmd = cmd_valid && (cmd_code == meter_seq_pkg::cmd_bus_trigger);
	// only a bus trigger slips through a running initiate
	// a clear in the same cycle drops a command taken in idle, so ready must not claim it was taken
	assign cmd_ready = (idle && !device_clear) || (init_lock && bus_trg_cmd);
	wire take = cmd_valid && idle && !device_clear;
	wire is_cfg = take && (cmd_code == meter_seq_pkg::cmd_configure);
	wire is_meas = take && (cmd_code == meter_seq_pkg::cmd_measure);
	wire is_read = take && (cmd_code == meter_seq_pkg::cmd_read);
	wire is_init = take && (cmd_code == meter_seq_pkg::cmd_initiate);
	wire is_fetch = take && (cmd_code == meter_seq_pkg::cmd_fetch);
	wire is_cq = take && (cmd_code == meter_seq_pkg::cmd_config_query);
	wire is_route = take && (cmd_code == meter_seq_pkg::cmd_route);
	wire is_counts = take && (cmd_code == meter_seq_pkg::cmd_set_counts);
	wire preset = is_cfg || is_meas;
	wire [2*`COUNT_W-1:0] product = trig_cnt_ff * samp_cnt_ff;
	wire too_many = (product > (2*`COUNT_W)'(`MEM_DEPTH));
	wire init_ok = is_init && !too_many;
	wire [`RANGE_W:0] rdec = decode_range(cmd_range_kind, cmd_range_value);
	wire two_ch = (cmd_func == meter_seq_pkg::fn_ratio) || (cmd_func == meter_seq_pkg::fn_diff);

	// trigger condition
	wire bus_trig = bus_trg_cmd || group_execute_trigger;
	wire trig_hit = (src_ff == meter_seq_pkg::src_immediate) ||
		(src_ff == meter_seq_pkg::src_bus && bus_trig) ||
		(src_ff == meter_seq_pkg::src_external && ext_trigger);

	// fifo path
	wire to_fifo_mode = (mode_ff != meter_seq_pkg::mode_init);
	wire fifo_in_ready;
	wire cq_push = cq_ff;
	wire rd_push = (state_ff == meter_seq_pkg::st_take) && conv_done && to_fifo_mode;
	wire f_push = (state_ff == meter_seq_pkg::st_fetch) && fetch_vld_ff;
	wire fifo_in_valid = rd_push || f_push || cq_push;
	// quote marker in the top byte, settings packed below it, low nibble spare
	wire [`DATA_W-1:0] cfg_word = {8'h22, 2'h0, func_ff, probe_ff, sub_ff, chan_ff,
		nplc_ff, rng_ff[chan_ff], auto_ff[chan_ff], 4'h0};
	wire [`DATA_W-1:0] fifo_in_data = cq_push ? cfg_word :
		(f_push ? fetch_data_ff : conv_data);
	// a full buffer holds the converter off rather than dropping a reading
	wire can_start = fifo_in_ready || !to_fifo_mode;
	wire mem_wr = (state_ff == meter_seq_pkg::st_take) && conv_done && !to_fifo_mode &&
		!no_store_ff;
	wire last_take = (taken_ff + `COUNT_W'(1)) >= total_ff;

	// next state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			meter_seq_pkg::st_idle: begin
				if (init_ok || is_read || is_meas) nxt_state = meter_seq_pkg::st_wait;
				else if (is_fetch) nxt_state = meter_seq_pkg::st_fetch;
			end
			meter_seq_pkg::st_wait: begin
				if (trig_hit && can_start) nxt_state = meter_seq_pkg::st_take;
			end
			meter_seq_pkg::st_take: begin
				if (conv_done && (mode_ff != meter_seq_pkg::mode_init || last_take))
					nxt_state = meter_seq_pkg::st_idle; // single reading, or the last reading of an initiate
				else if (conv_done) nxt_state = meter_seq_pkg::st_wait;
			end
			meter_seq_pkg::st_fetch: begin
				if (fetch_ff >= wr_cnt_ff && !fetch_vld_ff) nxt_state = meter_seq_pkg::st_idle;
			end
			default: nxt_state = meter_seq_pkg::st_idle;
		endcase
		if (device_clear) nxt_state = meter_seq_pkg::st_idle;
	end

	// trigger state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) state_ff <= meter_seq_pkg::st_idle;
		else state_ff <= nxt_state;
	end

	// sequence mode and counters
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= meter_seq_pkg::mode_read;
			taken_ff <= '0;
			total_ff <= '0;
			wr_cnt_ff <= '0;
			stat_ff <= '0;
			err_ff <= 1'b0;
			cq_ff <= 1'b0;
		end else begin
			cq_ff <= is_cq && fifo_in_ready;
			if (is_init && too_many) err_ff <= 1'b1;
			else if (init_ok) err_ff <= 1'b0;
			if (init_ok) begin
				mode_ff <= meter_seq_pkg::mode_init;
				taken_ff <= '0;
				total_ff <= product[`COUNT_W-1:0];
				wr_cnt_ff <= '0;
				stat_ff <= '0;
			end else if (is_read) begin
				mode_ff <= meter_seq_pkg::mode_read;
			end else if (is_meas) begin
				mode_ff <= meter_seq_pkg::mode_meas;
			end
			if (state_ff == meter_seq_pkg::st_take && conv_done) begin
				taken_ff <= taken_ff + `COUNT_W'(1);
				if (!to_fifo_mode) stat_ff <= stat_ff + `COUNT_W'(1);
				if (mem_wr) wr_cnt_ff <= wr_cnt_ff + `COUNT_W'(1);
			end
		end
	end

	// reading memory, written in acquisition order
	always_ff @(posedge clock) begin
		if (mem_wr) rmem[wr_cnt_ff[`MEM_AW-1:0]] <= conv_data;
		if (state_ff == meter_seq_pkg::st_fetch && !fetch_vld_ff)
			fetch_data_ff <= rmem[fetch_ff[`MEM_AW-1:0]];
	end

	// fetch walk: one memory word staged at a time
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fetch_ff <= '0;
			fetch_vld_ff <= 1'b0;
		end else if (device_clear || is_fetch) begin
			fetch_ff <= '0;
			fetch_vld_ff <= 1'b0;
		end else if (state_ff == meter_seq_pkg::st_fetch) begin
			if (!fetch_vld_ff && fetch_ff < wr_cnt_ff) begin
				fetch_vld_ff <= 1'b1;
				fetch_ff <= fetch_ff + `COUNT_W'(1);
			end else if (fetch_vld_ff && fifo_in_ready && !cq_push) begin
				fetch_vld_ff <= 1'b0;
			end
		end
	end

	// converter start, one pulse per trigger
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) conv_start <= 1'b0;
		else conv_start <= (state_ff == meter_seq_pkg::st_wait) && trig_hit && can_start &&
			!device_clear;
	end

	// configuration: configure and measure reset volatile settings
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			src_ff <= meter_seq_pkg::src_immediate;
			trig_cnt_ff <= `TRIG_COUNT_DEF;
			samp_cnt_ff <= `SAMPLE_COUNT_DEF;
			no_store_ff <= 1'b0;
			chan_ff <= 1'b0;
			nplc_ff <= `NPLC_DEF;
			func_ff <= meter_seq_pkg::fn_volt;
			probe_ff <= meter_seq_pkg::junction_pair_probe;
			sub_ff <= 4'h0;
			rng_ff[0] <= `RANGE_HIGHEST;
			rng_ff[1] <= `RANGE_HIGHEST;
			auto_ff[0] <= 1'b1;
			auto_ff[1] <= 1'b1;
		end else if (preset) begin
			// other parameters back to their defaults
			src_ff <= is_meas ? meter_seq_pkg::src_immediate : meter_seq_pkg::src_immediate;
			trig_cnt_ff <= `TRIG_COUNT_DEF;
			samp_cnt_ff <= `SAMPLE_COUNT_DEF;
			no_store_ff <= 1'b0;
			func_ff <= cmd_func;
			nplc_ff <= decode_res(cmd_res_kind, cmd_res_nplc);
			chan_ff <= two_ch ? 1'b0 : cmd_channel;
			rng_ff[two_ch ? 1'b0 : cmd_channel] <= rdec[`RANGE_W-1:0];
			auto_ff[two_ch ? 1'b0 : cmd_channel] <= rdec[`RANGE_W];
			if (two_ch) auto_ff[1] <= 1'b1;
			if (cmd_func == meter_seq_pkg::fn_temp && cmd_probe != meter_seq_pkg::probe_default) begin
				probe_ff <= cmd_probe; // default keeps last kind
				sub_ff <= cmd_probe_subtype;
			end
		end else begin
			if (is_route) chan_ff <= cmd_channel;
			if (is_counts) begin
				src_ff <= cmd_trig_src;
				trig_cnt_ff <= cmd_trig_count;
				samp_cnt_ff <= cmd_sample_count;
				no_store_ff <= cmd_no_store;
			end
		end
	end

	reading_fifo #(
		.WIDTH(`DATA_W),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.flush(device_clear),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_data)
	);

	// status outputs
	assign busy = !idle;
	assign waiting_trigger = (state_ff == meter_seq_pkg::st_wait);
	assign memory_error = err_ff;
	assign stored_count = wr_cnt_ff;
	assign stat_count = stat_ff;
	assign active_channel = chan_ff;
	assign ch_range_0 = rng_ff[0];
	assign ch_range_1 = rng_ff[1];
	assign ch_auto_0 = auto_ff[0];
	assign ch_auto_1 = auto_ff[1];
	assign nplc = nplc_ff;
	assign func_now = func_ff;
	assign probe_now = probe_ff;
	assign probe_subtype_now = sub_ff;
endmodule
`default_nettype wire

//--- conv_model.sv
// converter partner model answering conversion starts
`timescale 1ns/1ps
`default_nettype none
`include "meter_seq_defs.svh"
module conv_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// converter handshake
	input wire logic conv_start,
	output logic conv_done,
	output logic [`DATA_W-1:0] conv_data,
	// bench controls
	input wire logic [`DATA_W-1:0] next_word,
	input wire logic [3:0] lag
);
	logic [3:0] cnt_ff;
	logic run_ff;
	// data toggles outside done so a stale word is never mistaken for a fresh one
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			run_ff <= 1'b0;
			cnt_ff <= 4'h0;
			conv_done <= 1'b0;
			conv_data <= 32'h0;
		end else begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
			if (conv_start) begin
				run_ff <= 1'b1;
				cnt_ff <= lag;
			end else if (run_ff && cnt_ff == 4'h0) begin
				run_ff <= 1'b0;
				conv_done <= 1'b1;
				conv_data <= next_word;
			end else if (run_ff) begin
				cnt_ff <= cnt_ff - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

//--- meter_seq_properties.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "meter_seq_defs.svh"
module meter_seq_properties (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// command port
	input wire logic cmd_valid,
	input wire meter_seq_pkg::cmd_t cmd_code,
	input wire logic cmd_ready,
	input wire meter_seq_pkg::func_t cmd_func,
	input wire meter_seq_pkg::arg_t cmd_range_kind,
	input wire meter_seq_pkg::arg_t cmd_res_kind,
	input wire logic cmd_channel,
	input wire logic device_clear,
	// status
	input wire logic conv_start,
	input wire logic busy,
	input wire logic waiting_trigger,
	input wire logic [`RANGE_W-1:0] ch_range_0,
	input wire logic ch_auto_0,
	input wire logic ch_auto_1,
	input wire logic [`NPLC_W-1:0] nplc
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// accepted commands decoded once
	wire take = cmd_valid && cmd_ready;
	wire cfg = take && cmd_code == meter_seq_pkg::cmd_configure;
	wire preset = cfg || (take && cmd_code == meter_seq_pkg::cmd_measure);
	wire volt0 = cfg && cmd_func == meter_seq_pkg::fn_volt && !cmd_channel;
	AST_MEAS_WAIT: assert property (take && (cmd_code == meter_seq_pkg::cmd_measure ||
		cmd_code == meter_seq_pkg::cmd_read) |=> waiting_trigger) else $error("no wait state");
	AST_CFG_IDLE: assert property (cfg |=> (!busy && !conv_start) [*2])
		else $error("configure started a reading");
	AST_RANGE_MAX: assert property (volt0 && cmd_range_kind == meter_seq_pkg::arg_max
		|=> ch_range_0 == `RANGE_HIGHEST && !ch_auto_0) else $error("max range wrong");
	AST_RANGE_AUTO: assert property (volt0 && cmd_range_kind == meter_seq_pkg::arg_def
		|=> ch_auto_0) else $error("default range not auto");
	AST_RES_MIN: assert property (preset && cmd_res_kind == meter_seq_pkg::arg_min
		|=> nplc == `NPLC_MAX) else $error("min resolution wrong");
	AST_RES_DEF: assert property (preset && cmd_res_kind == meter_seq_pkg::arg_def
		|=> nplc == `NPLC_DEF) else $error("default resolution wrong");
	AST_RATIO_AUTO: assert property (cfg && (cmd_func == meter_seq_pkg::fn_ratio ||
		cmd_func == meter_seq_pkg::fn_diff) |=> ch_auto_1) else $error("channel two not auto");
	AST_REFUSE: assert property (busy && cmd_code != meter_seq_pkg::cmd_bus_trigger
		|-> !cmd_ready) else $error("command taken while busy");
	AST_CLEAR: assert property (device_clear |-> ##[1:2] !busy)
		else $error("clear did not abort");
endmodule
bind meter_seq meter_seq_properties u_props (.clock(clock), .rst_n(rst_n),
	.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready), .cmd_func(cmd_func),
	.cmd_range_kind(cmd_range_kind), .cmd_res_kind(cmd_res_kind), .cmd_channel(cmd_channel),
	.device_clear(device_clear), .conv_start(conv_start), .busy(busy),
	.waiting_trigger(waiting_trigger), .ch_range_0(ch_range_0), .ch_auto_0(ch_auto_0),
	.ch_auto_1(ch_auto_1), .nplc(nplc));
`default_nettype wire

//--- meter_measure_command_sequencer_tb.sv
// self-checking bench for the measurement command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "meter_seq_defs.svh"
`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("mismatch at %0t got %h expected %h", $time, (g), (e)); \
	end \
end
module meter_measure_command_sequencer_tb;
	logic clock, rst_n, cmd_valid, cmd_ready, cmd_channel, cmd_no_store, device_clear;
	logic group_execute_trigger, ext_trigger, conv_start, conv_done, out_valid, out_ready;
	logic busy, waiting_trigger, memory_error, active_channel, ch_auto_0, ch_auto_1;
	meter_seq_pkg::cmd_t cmd_code;
	meter_seq_pkg::func_t cmd_func;
	meter_seq_pkg::arg_t cmd_range_kind, cmd_res_kind;
	meter_seq_pkg::probe_t cmd_probe;
	meter_seq_pkg::trig_src_t cmd_trig_src;
	logic [3:0] cmd_range_value, cmd_probe_subtype, probe_subtype_now, ch_range_0, ch_range_1, lag;
	logic [3:0] sub_exp;
	logic [2:0] cmd_res_nplc, nplc, func_now;
	logic [1:0] probe_now;
	logic [10:0] cmd_trig_count, cmd_sample_count, stored_count, stat_count;
	logic [31:0] conv_data, out_data, word, got, want;
	logic [31:0] exp_q[$], msk_q[$], mem_q[$];
	int error_cnt = 0, tests_run = 0, convs = 0;
	meter_seq DUT (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_ready(cmd_ready), .cmd_func(cmd_func), .cmd_range_kind(cmd_range_kind),
		.cmd_range_value(cmd_range_value), .cmd_res_kind(cmd_res_kind), .cmd_res_nplc(cmd_res_nplc),
		.cmd_channel(cmd_channel), .cmd_probe(cmd_probe), .cmd_probe_subtype(cmd_probe_subtype),
		.cmd_trig_src(cmd_trig_src), .cmd_trig_count(cmd_trig_count),
		.cmd_sample_count(cmd_sample_count), .cmd_no_store(cmd_no_store),
		.device_clear(device_clear), .group_execute_trigger(group_execute_trigger),
		.ext_trigger(ext_trigger), .conv_start(conv_start), .conv_done(conv_done),
		.conv_data(conv_data), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
		.busy(busy), .waiting_trigger(waiting_trigger), .memory_error(memory_error),
		.stored_count(stored_count), .stat_count(stat_count), .active_channel(active_channel),
		.ch_range_0(ch_range_0), .ch_range_1(ch_range_1), .ch_auto_0(ch_auto_0),
		.ch_auto_1(ch_auto_1), .nplc(nplc), .func_now(func_now), .probe_now(probe_now),
		.probe_subtype_now(probe_subtype_now));
	conv_model u_conv (.clock(clock), .rst_n(rst_n), .conv_start(conv_start),
		.conv_done(conv_done), .conv_data(conv_data), .next_word(word), .lag(lag));
	// ****************
	// clock and watchers
	// ****************
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// popped words are compared against the oldest note; masks hide unspecified bits
	// sampled mid-cycle: a word seen here with ready high is popped at the next rising edge
	always @(negedge clock) begin
		if (rst_n && conv_start === 1'b1) convs++;
		if (rst_n && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0) `CHK(out_valid, 1'b0)
			else begin
				got = out_data & msk_q.pop_front();
				want = exp_q.pop_front();
				`CHK(got, want)
			end
		end
	end
	task results;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// bounded wait: 0 idle, 1 one stored reading, 2 notes drained
	task settle(input int k);
		int n;
		n = 0;
		while (n < 3000 && (k == 0 ? busy !== 1'b0 :
				k == 1 ? stored_count !== 11'h1 : exp_q.size() != 0)) begin
			@(negedge clock);
			n++;
		end
		if (n == 3000) begin
			error_cnt++;
			results();
		end
	endtask
	// request held until ready is seen, then dropped after the taking edge
	task go(input meter_seq_pkg::cmd_t c);
		int n;
		@(posedge clock);
		#2;
		cmd_code = c;
		cmd_valid = 1'b1;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (cmd_ready !== 1'b1 && n < 3000);
		if (n == 3000) begin
			error_cnt++;
			results();
		end
		@(posedge clock);
		#2;
		cmd_valid = 1'b0;
		repeat (2) @(posedge clock);
		// return off the edge so callers never change inputs as the design samples them
		#2;
	endtask
	task counts(input meter_seq_pkg::trig_src_t s, input int tc, input int sc, input logic ns);
		cmd_trig_src = s;
		cmd_trig_count = 11'(tc);
		cmd_sample_count = 11'(sc);
		cmd_no_store = ns;
		go(meter_seq_pkg::cmd_set_counts);
	endtask
	task setup(input meter_seq_pkg::func_t f, input meter_seq_pkg::arg_t r,
		input meter_seq_pkg::arg_t s, input logic ch);
		cmd_func = f;
		cmd_range_kind = r; // a range always rides with the resolution
		cmd_res_kind = s;
		cmd_channel = ch;
		go(meter_seq_pkg::cmd_configure);
	endtask
	// 0 external trigger, 1 group trigger, 2 device clear
	task fire(input int k);
		@(posedge clock);
		#2;
		ext_trigger = (k == 0);
		group_execute_trigger = (k == 1);
		device_clear = (k == 2);
		@(posedge clock);
		#2;
		{ext_trigger, group_execute_trigger, device_clear} = 3'h0;
	endtask
	// ****************
	// main sequence
	// ****************
	initial begin
		{rst_n, cmd_valid, cmd_channel, cmd_no_store} = 4'h0;
		{device_clear, group_execute_trigger, ext_trigger} = 3'h0;
		{cmd_range_value, cmd_probe_subtype, cmd_res_nplc, cmd_trig_count, cmd_sample_count, lag} = 0;
		cmd_code = meter_seq_pkg::cmd_none;
		cmd_func = meter_seq_pkg::fn_volt;
		cmd_range_kind = meter_seq_pkg::arg_value;
		cmd_res_kind = meter_seq_pkg::arg_value;
		cmd_probe = meter_seq_pkg::junction_pair_probe;
		cmd_trig_src = meter_seq_pkg::src_immediate;
		out_ready = 1'b1;
		word = $urandom(32'h7c11);
		repeat (8) @(posedge clock);
		#2 rst_n = 1'b1;
		`CHK({ch_auto_0, ch_range_0, nplc}, {1'b1, `RANGE_HIGHEST, `NPLC_DEF})
		setup(meter_seq_pkg::fn_volt, meter_seq_pkg::arg_max, meter_seq_pkg::arg_min, 1'b0);
		`CHK({ch_range_0, ch_auto_0, nplc}, {`RANGE_HIGHEST, 1'b0, `NPLC_MAX})
		`CHK({busy, waiting_trigger, convs}, {2'b00, 32'h0})
		setup(meter_seq_pkg::fn_volt, meter_seq_pkg::arg_min, meter_seq_pkg::arg_def, 1'b1);
		`CHK({ch_range_1, ch_range_0, nplc}, {`RANGE_LOWEST, `RANGE_HIGHEST, `NPLC_DEF})
		// route back to channel one; channel two keeps its own range
		cmd_channel = 1'b0;
		go(meter_seq_pkg::cmd_route);
		`CHK({active_channel, ch_range_1}, {1'b0, `RANGE_LOWEST})
		setup(meter_seq_pkg::fn_volt, meter_seq_pkg::arg_def, meter_seq_pkg::arg_max, 1'b0);
		`CHK({ch_auto_0, nplc}, {1'b1, `NPLC_MIN})
		setup(meter_seq_pkg::fn_ratio, meter_seq_pkg::arg_max, meter_seq_pkg::arg_def, 1'b0);
		`CHK({ch_auto_1, ch_auto_0}, 2'b10)
		for (int p = 0; p < 4; p++) begin
			cmd_probe = meter_seq_pkg::probe_t'(p);
			cmd_probe_subtype = 4'($urandom_range(0, 7));
			if (p < 3) sub_exp = cmd_probe_subtype;
			setup(meter_seq_pkg::fn_temp, meter_seq_pkg::arg_def, meter_seq_pkg::arg_def, 1'b0);
			`CHK(probe_now, (p == 3) ? 2'h2 : 2'(p))
			`CHK({func_now, probe_subtype_now}, {meter_seq_pkg::fn_temp, sub_exp})
		end
		exp_q.push_back(32'h222c0000);
		msk_q.push_back(32'hff3e0000);
		go(meter_seq_pkg::cmd_config_query);
		settle(2);
		counts(meter_seq_pkg::src_external, 1, 1, 1'b0);
		go(meter_seq_pkg::cmd_read);
		`CHK({waiting_trigger, convs}, {1'b1, 32'h0})
		word = $urandom;
		exp_q.push_back(word);
		msk_q.push_back(32'hffffffff);
		fire(0);
		settle(2);
		`CHK(stored_count, 11'h0)
		counts(meter_seq_pkg::src_bus, 2, 1, 1'b0);
		go(meter_seq_pkg::cmd_initiate);
		`CHK(stored_count, 11'h0)
		cmd_code = meter_seq_pkg::cmd_configure;
		@(negedge clock);
		`CHK({busy, cmd_ready}, 2'b10)
		word = $urandom;
		mem_q.push_back(word);
		go(meter_seq_pkg::cmd_bus_trigger);
		settle(1);
		word = $urandom;
		mem_q.push_back(word);
		fire(1);
		settle(0);
		`CHK(stored_count, 11'h2)
		while (mem_q.size() > 0) begin
			exp_q.push_back(mem_q.pop_front());
			msk_q.push_back(32'hffffffff);
		end
		go(meter_seq_pkg::cmd_fetch);
		settle(2);
		counts(meter_seq_pkg::src_bus, 33, 32, 1'b0);
		go(meter_seq_pkg::cmd_initiate);
		`CHK({memory_error, busy}, 2'b10)
		counts(meter_seq_pkg::src_bus, 32, 32, 1'b0);
		go(meter_seq_pkg::cmd_initiate);
		`CHK({memory_error, waiting_trigger}, 2'b01)
		`CHK(stored_count, 11'h0)
		fire(2);
		`CHK({busy, waiting_trigger}, 2'b00)
		counts(meter_seq_pkg::src_immediate, 1, 1, 1'b1);
		go(meter_seq_pkg::cmd_initiate);
		settle(0);
		`CHK({stored_count, stat_count}, {11'h0, 11'h1})
		counts(meter_seq_pkg::src_external, 1, 1, 1'b0);
		out_ready = 1'b0;
		for (int i = 0; i < 9; i++) begin
			word = $urandom;
			lag = 4'($urandom_range(0, 5));
			exp_q.push_back(word);
			msk_q.push_back(32'hffffffff);
			go(meter_seq_pkg::cmd_measure);
			if (i < 8) settle(0);
		end
		repeat (20) @(posedge clock);
		`CHK(waiting_trigger, 1'b1)
		#2 out_ready = 1'b1;
		settle(2);
		settle(0);
		results();
	end
endmodule
`default_nettype wire
